// ===== verilog/wsr_pkg.sv
// package for the watchdog, sleep and reset control block
package wsr_pkg;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0]  IDX_WDT_SEL  = 8'h09;
	// byte address is four times the register index
	localparam logic [11:0] ADDR_WDT_SEL = {2'h0, IDX_WDT_SEL, 2'h0};
	localparam logic [11:0] ADDR_STATUS  = 12'h100;
	localparam logic [11:0] ADDR_CONFIG  = 12'h104;
	// ----------------------------------------
	// fields and reset values
	// ----------------------------------------
	localparam int          RATIO_LSB     = 0;
	localparam int          RATIO_W       = 3;
	localparam logic [7:0]  WDT_SEL_RST   = 8'h07;
	localparam int          ST_EXP_BIT    = 0;
	localparam int          ST_SLP_BIT    = 1;
	localparam int          ST_ASLEEP_BIT = 2;
	localparam int          ST_STARTUP_BIT = 3;
	// config: [0] wdt enable, [1] use own osc, [2] paired clear, [15:8] port A wake enables
	localparam int          CFG_EN_BIT    = 0;
	localparam int          CFG_OSC_BIT   = 1;
	localparam int          CFG_PAIR_BIT  = 2;
	localparam int          CFG_WAKE_LSB  = 8;
	localparam logic [15:0] CFG_RST       = 16'h0003;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int          INSTR_DIV     = 4;
	localparam int          FIXED_DIV     = 256;
	localparam int          STARTUP_CLKS  = 1024;
	localparam int          CFG_LOAD_CLKS = 16;
	localparam logic [31:0] PC_RESET      = 32'h0000_0000;
	// ----------------------------------------
	// sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		WSR_RUN    = 2'b00,
		WSR_SLEEP  = 2'b01,
		WSR_CFGLD  = 2'b10,
		WSR_START  = 2'b11
	} wsr_state_t;
endpackage : wsr_pkg

// ===== verilog/wsr_top.sv
// watchdog, sleep control, start-up delay and reset-cause flags
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module wsr_top #(
	parameter int STARTUP_CYC = wsr_pkg::STARTUP_CLKS,
	parameter int CFGLD_CYC   = wsr_pkg::CFG_LOAD_CLKS
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	// core instructions
	input  wire logic        clr_single,
	input  wire logic        clr_first,
	input  wire logic        clr_second,
	input  wire logic        sleep_instr,
	// wake sources
	input  wire logic        external_clear_pin_n,
	input  wire logic [7:0]  port_a_in,
	input  wire logic        irq_req,
	input  wire logic        irq_enabled,
	input  wire logic        stack_full,
	input  wire logic        wdt_osc_tick,
	// core control
	output logic             core_hold,
	output logic             sys_osc_stop,
	output logic             full_reset,
	output logic             warm_reset,
	output logic             resume_next,
	output logic             irq_take,
	output logic             ports_input,
	output logic             irq_disable
);
	localparam int CW = 11;

	typedef struct packed {
		wsr_pkg::wsr_state_t st;
		logic [7:0]          wsel;
		logic [15:0]         cfg;
		logic                expired;
		logic                slept;
		logic [1:0]          div4;
		logic [7:0]          fixdiv;
		logic [6:0]          pre;
		logic                arm1;
		logic                arm2;
		logic [CW-1:0]       cnt;
		logic [7:0]          pa_q;
		logic                irq_at_sleep;
		logic                wake_irq;
		logic                pin_q;
		logic                irq_go;
		logic [31:0]         rdata;
		logic                full_rst;
		logic                warm_rst;
		logic                resume;
	} wsr_state_s_t;

	wsr_state_s_t s_ff;
	wsr_state_s_t nxt_s;

	logic       wr;
	logic       rd;
	logic       wdt_en;
	logic       tick;
	logic       clr;
	logic       ovf;
	logic       pre_hit;
	logic [7:0] pa_fall;
	logic       pin_fall;

	assign wdt_en = s_ff.cfg[wsr_pkg::CFG_EN_BIT];
	assign wr     = psel && penable && pwrite;
	// read data is captured in the setup cycle so it stands at the access edge
	assign rd     = psel && !penable && !pwrite;
	assign pa_fall  = s_ff.pa_q & ~port_a_in & s_ff.cfg[wsr_pkg::CFG_WAKE_LSB +: 8];
	assign pin_fall = s_ff.pin_q && !external_clear_pin_n;

	// ----------------------------------------
	// watchdog tick and counter
	// ----------------------------------------
	always_comb begin
		// own oscillator runs in sleep; instruction clock stops with the system clock
		if (s_ff.cfg[wsr_pkg::CFG_OSC_BIT]) begin
			tick = wdt_osc_tick;
		end else begin
			tick = (s_ff.div4 == 2'(wsr_pkg::INSTR_DIV - 1))
				&& (s_ff.st != wsr_pkg::WSR_SLEEP);
		end
		tick = tick && wdt_en;
	end

	always_comb begin
		// prescaler wraps after 2^ratio base periods
		logic [2:0] r;
		logic [6:0] mask;
		r = s_ff.wsel[wsr_pkg::RATIO_LSB +: wsr_pkg::RATIO_W];
		mask = 7'((8'h01 << r) - 8'h01);
		pre_hit = ((s_ff.pre & mask) == mask);
	end

	assign ovf = tick && (s_ff.fixdiv == 8'(wsr_pkg::FIXED_DIV - 1)) && pre_hit
		&& (s_ff.st == wsr_pkg::WSR_RUN || s_ff.st == wsr_pkg::WSR_SLEEP);

	always_comb begin
		if (!wdt_en) begin
			clr = 1'b0;
		end else if (s_ff.cfg[wsr_pkg::CFG_PAIR_BIT]) begin
			clr = (s_ff.arm1 || clr_first) && (s_ff.arm2 || clr_second);
		end else begin
			clr = clr_single;
		end
	end

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		logic wake;
		logic run;
		nxt_s = s_ff;
		wake = 1'b0;
		run = (s_ff.st == wsr_pkg::WSR_RUN);
		nxt_s.pa_q   = port_a_in;
		nxt_s.pin_q  = external_clear_pin_n;
		nxt_s.full_rst = 1'b0;
		nxt_s.warm_rst = 1'b0;
		nxt_s.resume   = 1'b0;
		nxt_s.irq_go   = 1'b0;
		nxt_s.div4 = s_ff.div4 + 2'h1;
		// watchdog divider chain
		if (tick) begin
			nxt_s.fixdiv = s_ff.fixdiv + 8'h01;
			if (s_ff.fixdiv == 8'hFF) begin
				nxt_s.pre = pre_hit ? 7'h00 : s_ff.pre + 7'h01;
			end
		end
		// pairing markers
		if (s_ff.cfg[wsr_pkg::CFG_PAIR_BIT] && wdt_en && run) begin
			nxt_s.arm1 = s_ff.arm1 || clr_first;
			nxt_s.arm2 = s_ff.arm2 || clr_second;
			if (clr) begin
				nxt_s.arm1 = 1'b0;
				nxt_s.arm2 = 1'b0;
			end
		end
		// apb writes
		if (wr && paddr == wsr_pkg::ADDR_WDT_SEL) begin
			nxt_s.wsel = pwdata[7:0];
		end
		if (wr && paddr == wsr_pkg::ADDR_CONFIG) begin
			nxt_s.cfg = pwdata[15:0];
		end
		nxt_s.rdata = 32'h0000_0000;
		if (rd) begin
			case (paddr)
				wsr_pkg::ADDR_WDT_SEL: nxt_s.rdata = {24'h000000, s_ff.wsel};
				wsr_pkg::ADDR_CONFIG:  nxt_s.rdata = {16'h0000, s_ff.cfg};
				wsr_pkg::ADDR_STATUS:  nxt_s.rdata = {28'h0000000,
					s_ff.st == wsr_pkg::WSR_START || s_ff.st == wsr_pkg::WSR_CFGLD,
					s_ff.st == wsr_pkg::WSR_SLEEP, s_ff.slept, s_ff.expired};
				default:               nxt_s.rdata = 32'h0000_0000;
			endcase
		end
		if (s_ff.cnt != '0) begin
			nxt_s.cnt = s_ff.cnt - CW'(1);
		end
		case (s_ff.st)
			wsr_pkg::WSR_RUN: begin
				// interrupt entry one cycle after the start-up delay has ended
				if (s_ff.wake_irq) begin
					nxt_s.irq_go = 1'b1;
					nxt_s.wake_irq = 1'b0;
				end
				if (clr) begin
					nxt_s.fixdiv = 8'h00;
					nxt_s.pre = 7'h00;
					if (!s_ff.cfg[wsr_pkg::CFG_PAIR_BIT]) begin
						nxt_s.slept = 1'b0;
					end
				end
				if (!external_clear_pin_n) begin
					// pin reset while running leaves flags
					nxt_s.fixdiv = 8'h00;
					nxt_s.arm1 = 1'b0;
					nxt_s.arm2 = 1'b0;
					nxt_s.pre = 7'h00;
					nxt_s.full_rst = 1'b1;
					nxt_s.st = wsr_pkg::WSR_CFGLD;
					nxt_s.cnt = CW'(CFGLD_CYC);
				end else if (ovf) begin
					nxt_s.expired = 1'b1;
					nxt_s.full_rst = 1'b1;
					nxt_s.arm1 = 1'b0;
					nxt_s.arm2 = 1'b0;
					nxt_s.wsel = wsr_pkg::WDT_SEL_RST;
					nxt_s.fixdiv = 8'h00;
					nxt_s.pre = 7'h00;
					nxt_s.st = wsr_pkg::WSR_CFGLD;
					nxt_s.cnt = CW'(CFGLD_CYC);
				end else if (sleep_instr) begin
					nxt_s.slept = 1'b1;
					nxt_s.expired = 1'b0;
					nxt_s.fixdiv = 8'h00;
					nxt_s.pre = 7'h00;
					nxt_s.irq_at_sleep = irq_req;
					nxt_s.st = wsr_pkg::WSR_SLEEP;
				end
			end
			wsr_pkg::WSR_SLEEP: begin
				nxt_s.wake_irq = 1'b0;
				if (!irq_req) begin
					nxt_s.irq_at_sleep = 1'b0;
				end
				if (!external_clear_pin_n) begin
					nxt_s.expired = 1'b0; // pin wake 0,1
					nxt_s.arm1 = 1'b0;
					nxt_s.arm2 = 1'b0;
					nxt_s.full_rst = 1'b1;
					nxt_s.wsel = wsr_pkg::WDT_SEL_RST;
					nxt_s.fixdiv = 8'h00;
					nxt_s.pre = 7'h00;
					nxt_s.st = wsr_pkg::WSR_CFGLD;
					nxt_s.cnt = CW'(CFGLD_CYC);
				end else if (ovf) begin
					nxt_s.expired = 1'b1;
					nxt_s.warm_rst = 1'b1;
					wake = 1'b1;
				end else if (irq_req && !s_ff.irq_at_sleep) begin
					nxt_s.wake_irq = irq_enabled && !stack_full;
					wake = 1'b1;
				end else if (pa_fall != 8'h00) begin
					wake = 1'b1;
				end
				if (wake) begin
					nxt_s.st = wsr_pkg::WSR_START;
					nxt_s.cnt = CW'(STARTUP_CYC - 1);
				end
			end
			wsr_pkg::WSR_CFGLD: begin
				if (s_ff.cnt == '0) begin
					nxt_s.st = wsr_pkg::WSR_START;
					nxt_s.cnt = CW'(STARTUP_CYC - 1);
				end
			end
			wsr_pkg::WSR_START: begin
				if (s_ff.cnt == '0) begin
					nxt_s.st = wsr_pkg::WSR_RUN;
					nxt_s.resume = !s_ff.wake_irq;
				end
			end
			default: nxt_s.st = wsr_pkg::WSR_RUN;
		endcase
		if (!pin_fall && !external_clear_pin_n && s_ff.st == wsr_pkg::WSR_CFGLD) begin
			nxt_s.cnt = CW'(CFGLD_CYC); // hold while pin low
			nxt_s.fixdiv = 8'h00;
			nxt_s.pre = 7'h00;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_ff          <= '0; // power-up flags 0,0
			s_ff.st       <= wsr_pkg::WSR_CFGLD;
			s_ff.cnt      <= CW'(CFGLD_CYC);
			s_ff.wsel     <= wsr_pkg::WDT_SEL_RST;
			s_ff.cfg      <= wsr_pkg::CFG_RST;
			s_ff.pin_q    <= 1'b1;
			s_ff.pa_q     <= 8'hFF;
			s_ff.full_rst <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign pready       = 1'b1;
	assign pslverr      = 1'b0;
	assign prdata       = s_ff.rdata;
	assign core_hold    = (s_ff.st != wsr_pkg::WSR_RUN) || s_ff.wake_irq;
	assign sys_osc_stop = (s_ff.st == wsr_pkg::WSR_SLEEP);
	assign full_reset   = s_ff.full_rst;
	assign warm_reset   = s_ff.warm_rst;
	assign resume_next  = s_ff.resume;
	assign irq_take     = s_ff.irq_go;
	assign ports_input  = s_ff.full_rst;
	assign irq_disable  = s_ff.full_rst;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_sleep_cmd;
		(s_ff.st == wsr_pkg::WSR_RUN) && sleep_instr && external_clear_pin_n && !ovf;
	endsequence

	property p_sleep_flags;
		@(posedge clk) disable iff (!rstn) s_sleep_cmd |=> s_ff.slept && !s_ff.expired;
	endproperty
	a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");

	property p_run_ovf;
		@(posedge clk) disable iff (!rstn)
			(s_ff.st == wsr_pkg::WSR_RUN) && ovf && external_clear_pin_n
			|=> full_reset && s_ff.expired && $stable(s_ff.slept);
	endproperty
	a_run_ovf: assert property (p_run_ovf) else $error("running overflow wrong");

	property p_sleep_ovf;
		@(posedge clk) disable iff (!rstn)
			(s_ff.st == wsr_pkg::WSR_SLEEP) && ovf && external_clear_pin_n
			|=> warm_reset && !full_reset && s_ff.expired && s_ff.slept;
	endproperty
	a_sleep_ovf: assert property (p_sleep_ovf) else $error("sleep overflow wrong");

	property p_disabled;
		@(posedge clk) disable iff (!rstn) !wdt_en |-> !ovf && !clr;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled watchdog acted");

	property p_startup;
		@(posedge clk) disable iff (!rstn)
			$rose(s_ff.st == wsr_pkg::WSR_START) |-> (s_ff.st == wsr_pkg::WSR_START)[*8];
	endproperty
	a_startup: assert property (p_startup) else $error("start-up delay short");

	property p_wake_no_cfg;
		@(posedge clk) disable iff (!rstn)
			(s_ff.st == wsr_pkg::WSR_SLEEP) ##1 ((s_ff.st != wsr_pkg::WSR_SLEEP)
			&& $past(external_clear_pin_n)) |-> s_ff.st == wsr_pkg::WSR_START;
	endproperty
	a_wake_no_cfg: assert property (p_wake_no_cfg) else $error("wake took config load");

	property p_inst_sleep;
		@(posedge clk) disable iff (!rstn)
			!s_ff.cfg[wsr_pkg::CFG_OSC_BIT] && (s_ff.st == wsr_pkg::WSR_SLEEP) |-> !tick;
	endproperty
	a_inst_sleep: assert property (p_inst_sleep) else $error("counted in sleep");

	property p_slept_clear;
		@(posedge clk) disable iff (!rstn)
			$fell(s_ff.slept) |-> $past(clr && !s_ff.cfg[wsr_pkg::CFG_PAIR_BIT]);
	endproperty
	a_slept_clear: assert property (p_slept_clear) else $error("sleep flag cleared wrongly");

	property p_irq_wake;
		@(posedge clk) disable iff (!rstn)
			irq_take |-> !resume_next && !core_hold && $past(s_ff.st == wsr_pkg::WSR_RUN);
	endproperty
	a_irq_wake: assert property (p_irq_wake) else $error("interrupt entry wrong");

endmodule : wsr_top

`default_nettype wire

// ===== tb/wsr_core_model.sv
// core model that issues clear and sleep instructions
`timescale 1ns/1ps
`default_nettype none
module wsr_core_model (
	// clock and run state
	input  wire logic clk,
	input  wire logic core_hold,
	// instruction pulses
	output logic      clr_single,
	output logic      clr_first,
	output logic      clr_second,
	output logic      sleep_instr
);
	initial {clr_single, clr_first, clr_second, sleep_instr} = 4'h0;
	// ----------------------------------------
	// op is {single, first, second, sleep}; one-cycle pulse, only while running
	// ----------------------------------------
	task automatic issue(input logic [3:0] op);
		@(negedge clk);
		while (core_hold !== 1'b0) begin
			@(negedge clk);
		end
		@(posedge clk);
		{clr_single, clr_first, clr_second, sleep_instr} <= op;
		@(posedge clk);
		{clr_single, clr_first, clr_second, sleep_instr} <= 4'h0;
	endtask : issue
endmodule : wsr_core_model
`default_nettype wire

// ===== tb/tb_watchdog_sleep_reset_control.sv
// self-checking bench for the watchdog, sleep and reset control block
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_sleep_reset_control;
	localparam int SU = 8;
	localparam logic [11:0] SEL = wsr_pkg::ADDR_WDT_SEL;
	localparam logic [11:0] STA = wsr_pkg::ADDR_STATUS;
	localparam logic [11:0] CFG = wsr_pkg::ADDR_CONFIG;
	logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        pin_n = 1'b1, irq_req = 1'b0, irq_en = 1'b1, stk_full = 1'b0, tick = 1'b0;
	logic        pready, pslverr, c_single, c_first, c_second, c_sleep;
	logic        hold, osc_stop, f_rst, w_rst, resume, take, p_in, i_dis;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic [7:0]  port_a = 8'hFF;
	int          err_total = 0, total_checks = 0, cyc = 0;
	int          seen[4];

	wsr_top #(.STARTUP_CYC(SU), .CFGLD_CYC(2)) u_dut (
		.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.clr_single(c_single), .clr_first(c_first), .clr_second(c_second),
		.sleep_instr(c_sleep), .external_clear_pin_n(pin_n), .port_a_in(port_a),
		.irq_req(irq_req), .irq_enabled(irq_en), .stack_full(stk_full), .wdt_osc_tick(tick),
		.core_hold(hold), .sys_osc_stop(osc_stop), .full_reset(f_rst), .warm_reset(w_rst),
		.resume_next(resume), .irq_take(take), .ports_input(p_in), .irq_disable(i_dis)
	);
	wsr_core_model u_core (
		.clk(clk), .core_hold(hold), .clr_single(c_single), .clr_first(c_first),
		.clr_second(c_second), .sleep_instr(c_sleep)
	);

	always #25 clk = ~clk;
	// own oscillator ticks every other cycle
	always @(posedge clk) begin
		tick <= ~tick;
		cyc  <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks=%0d errors=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic inr(input int v, input int lo, input int hi);
		chk({31'h0, v >= lo && v <= hi}, 32'h0000_0001);
	endtask : inr
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		chk({31'h0, pslverr}, 32'h0000_0000);
	endtask : apb
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask : rchk
	// first cycle each pulse shows: full, warm, resume, interrupt
	task automatic run(input int n);
		logic [3:0] ev;
		seen = '{-1, -1, -1, -1};
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			ev = {take, resume, w_rst, f_rst};
			for (int k = 0; k < 4; k++) begin
				if (ev[k] === 1'b1 && seen[k] < 0) seen[k] = i;
			end
			chk({30'h0, p_in, i_dis}, {30'h0, f_rst, f_rst});
		end
	endtask : run
	task automatic nap(input int n);
		u_core.issue(4'h1);
		run(n);
	endtask : nap

	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		run(30);
		rchk(SEL, 32'h0000_0007);
		rchk(STA, 32'h0000_0000);
		rchk(12'h200, 32'h0000_0000);
		apb(1'b1, SEL, 32'h0000_00F9);
		rchk(SEL, 32'h0000_00F9);
		repeat (3) begin
			u_core.issue(4'h8);
			run(900);
			inr(seen[0], -1, -1);
		end
		u_core.issue(4'h8);
		run(1100);
		inr(seen[0], 1000, 1100);
		run(20);
		rchk(STA, 32'h0000_0001);
		apb(1'b1, CFG, 32'h0000_0101);
		apb(1'b1, SEL, 32'h0000_0000);
		u_core.issue(4'h8);
		run(1100);
		inr(seen[0], 1000, 1100);
		run(20);
		apb(1'b1, CFG, 32'h0000_0101);
		apb(1'b1, SEL, 32'h0000_0000);
		nap(1500);
		chk({30'h0, osc_stop, hold}, 32'h0000_0003);
		inr(seen[0] + seen[1], -2, -2);
		@(posedge clk) port_a <= 8'hFE;
		run(20);
		inr(seen[2], SU - 1, SU + 3);
		@(posedge clk) port_a <= 8'hFF;
		rchk(STA, 32'h0000_0002);
		apb(1'b1, CFG, 32'h0000_0103);
		nap(600);
		inr(seen[1], 490, 560);
		inr(seen[0], -1, -1);
		run(20);
		rchk(STA, 32'h0000_0003);
		rchk(SEL, 32'h0000_0000);
		u_core.issue(4'h8);
		apb(1'b0, STA, 32'h0000_0000);
		chk(rd & 32'h0000_0002, 32'h0000_0000);
		@(posedge clk) irq_req <= 1'b1;
		nap(60);
		inr(seen[2] + seen[3], -2, -2);
		@(posedge clk) irq_req <= 1'b0;
		run(3);
		@(posedge clk) irq_req <= 1'b1;
		run(30);
		inr(seen[3], SU, SU + 4);
		inr(seen[2], -1, -1);
		@(posedge clk) irq_req <= 1'b0;
		stk_full <= 1'b1;
		nap(5);
		@(posedge clk) irq_req <= 1'b1;
		run(30);
		inr(seen[2], SU - 1, SU + 3);
		inr(seen[3], -1, -1);
		@(posedge clk) irq_req <= 1'b0;
		stk_full <= 1'b0;
		irq_en   <= 1'b0;
		nap(5);
		@(posedge clk) irq_req <= 1'b1;
		run(30);
		inr(seen[2], SU - 1, SU + 3);
		inr(seen[3], -1, -1);
		@(posedge clk) irq_req <= 1'b0;
		irq_en   <= 1'b1;
		apb(1'b1, CFG, 32'h0000_0107);
		apb(1'b1, SEL, 32'h0000_0001);
		repeat (2) begin
			u_core.issue(4'h2);
			u_core.issue(4'h4);
			run(900);
			inr(seen[0], -1, -1);
		end
		u_core.issue(4'h4);
		run(400);
		inr(seen[0], 50, 200);
		run(20);
		rchk(STA, 32'h0000_0003);
		@(posedge clk) pin_n <= 1'b0;
		run(4);
		inr(seen[0], 0, 3);
		@(posedge clk) pin_n <= 1'b1;
		run(30);
		rchk(STA, 32'h0000_0003);
		apb(1'b1, CFG, 32'h0000_0103);
		nap(5);
		@(posedge clk) pin_n <= 1'b0;
		run(4);
		@(posedge clk) pin_n <= 1'b1;
		run(30);
		rchk(STA, 32'h0000_0002);
		apb(1'b1, CFG, 32'h0000_0102);
		apb(1'b1, SEL, 32'h0000_0000);
		u_core.issue(4'h8);
		run(1200);
		inr(seen[0], -1, -1);
		close_out();
	end
endmodule : tb_watchdog_sleep_reset_control
`default_nettype wire
